// File: inc/tcu_pkg.sv
package tcu_pkg;

    // ********************************************************
    // Register locations on the 8-bit bus.
    // ********************************************************
    localparam logic [3:0] A_CNT_L  = 4'h0;
    localparam logic [3:0] A_CNT_H  = 4'h1;
    localparam logic [3:0] A_CAP_L  = 4'h2;
    localparam logic [3:0] A_CAP_H  = 4'h3;
    localparam logic [3:0] A_CMPA_L = 4'h4;
    localparam logic [3:0] A_CMPA_H = 4'h5;
    localparam logic [3:0] A_CTL_A  = 4'h6;
    localparam logic [3:0] A_CTL_B  = 4'h7;
    localparam logic [3:0] A_FLAG   = 4'h8;
    localparam logic [3:0] A_MASK   = 4'h9;

    // ********************************************************
    // Field positions.
    // ********************************************************
    localparam int CTLA_MODE_LO = 0;
    localparam int CTLB_CS      = 0;
    localparam int CTLB_MODE_HI = 3;
    localparam int CTLB_EDGE   = 6;
    localparam int FLAG_OVF    = 0;
    localparam int FLAG_CAP    = 5;

    // ********************************************************
    // Clock select codes and prescaler taps.
    // ********************************************************
    localparam logic [2:0] CS_STOP    = 3'h0;
    localparam logic [2:0] CS_DIV1    = 3'h1;
    localparam logic [2:0] CS_DIV8    = 3'h2;
    localparam logic [2:0] CS_DIV64   = 3'h3;
    localparam logic [2:0] CS_DIV256  = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [9:0] PS_M8    = 10'h007;
    localparam logic [9:0] PS_M64   = 10'h03f;
    localparam logic [9:0] PS_M256  = 10'h0ff;
    localparam logic [9:0] PS_M1024 = 10'h3ff;

    // ********************************************************
    // Count values and reset values.
    // ********************************************************
    localparam logic [15:0] CNT_ZERO  = 16'h0000;
    localparam logic [15:0] CNT_ONE   = 16'h0001;
    localparam logic [15:0] CNT_MAX   = 16'hffff;
    localparam logic [15:0] TOP_8BIT  = 16'h00ff;
    localparam logic [15:0] TOP_9BIT  = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    localparam logic [7:0]  BYTE_RST  = 8'h00;

    // ********************************************************
    // Wave modes.
    // ********************************************************
    localparam logic [3:0] M_NORMAL   = 4'h0;
    localparam logic [3:0] M_PC8      = 4'h1;
    localparam logic [3:0] M_PC9      = 4'h2;
    localparam logic [3:0] M_PC10     = 4'h3;
    localparam logic [3:0] M_CTC_CMP  = 4'h4;
    localparam logic [3:0] M_FAST8    = 4'h5;
    localparam logic [3:0] M_FAST9    = 4'h6;
    localparam logic [3:0] M_FAST10   = 4'h7;
    localparam logic [3:0] M_PFC_CAP  = 4'h8;
    localparam logic [3:0] M_PFC_CMP  = 4'h9;
    localparam logic [3:0] M_PC_CAP   = 4'ha;
    localparam logic [3:0] M_PC_CMP   = 4'hb;
    localparam logic [3:0] M_CTC_CAP  = 4'hc;
    localparam logic [3:0] M_FAST_CAP = 4'he;
    localparam logic [3:0] M_FAST_CMP = 4'hf;

    typedef enum logic {
        TCU_UP   = 1'b0,
        TCU_DOWN = 1'b1
    } tcu_dir_type;

endpackage : tcu_pkg

// File: rtl/tcu_edge.sv
`timescale 1ns/1ps
`default_nettype none
module tcu_edge
    import tcu_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic pin_in,
    output logic      rise,
    output logic      fall
);

    // ********************************************************
    // Two-stage synchroniser followed by the edge history.
    // ********************************************************
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic [2:0] live;
    } tcu_edge_state_type;

    tcu_edge_state_type s_q;
    tcu_edge_state_type s_d;

    always_comb
    begin
        s_d      = s_q;
        s_d.meta = pin_in;
        s_d.sync = s_q.meta;
        s_d.prev = s_q.sync;
        s_d.live = {s_q.live[1:0], 1'b1};
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Edges stay masked until the history holds real samples, so a pin
    // that idles high does not fake a rising edge after reset.
    assign rise = s_q.live[2] & s_q.sync & ~s_q.prev;
    assign fall = s_q.live[2] & ~s_q.sync & s_q.prev;

endmodule : tcu_edge
`default_nettype wire

// File: rtl/tcu_core.sv
`timescale 1ns/1ps
`default_nettype none
module tcu_core
    import tcu_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [3:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    input  wire logic       t1_pin,
    input  wire logic       capture_pin,
    input  wire logic       comparator_output,
    input  wire logic       comparator_source_select,
    input  wire logic       ovf_irq_ack,
    input  wire logic       cap_irq_ack,
    output logic            ovf_irq,
    output logic            cap_irq,
    output logic            count_top_hit,
    output logic            count_floor_hit
);

    // ********************************************************
    // State.
    // ********************************************************
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] capt;
        logic [15:0] cmpa;
        logic [7:0]  temp;
        logic [7:0]  ctl_a;
        logic [7:0]  ctl_b;
        logic [9:0]  presc;
        tcu_dir_type dir;
        logic        flag_ovf;
        logic        flag_cap;
        logic        msk_ovf;
        logic        msk_cap;
        logic [7:0]  rdata;
        logic        top_hit;
        logic        floor_hit;
        logic        ovf_irq;
        logic        cap_irq;
    } tcu_state_type;

    tcu_state_type s_q;
    tcu_state_type s_d;

    logic [3:0]  mode;
    logic [2:0]  csel;
    logic [15:0] top;
    logic        dual;
    logic        cap_top;
    logic        ovf_max;
    logic        tick;
    logic        cap_src;
    logic        cap_rise;
    logic        cap_fall;
    logic        t1_rise;
    logic        t1_fall;
    logic        cap_evt;
    logic        ovf_set;
    logic [7:0]  rd_val;

    // ********************************************************
    // Pin sampling and edge detection.
    // ********************************************************
    // The source mux sits ahead of the synchroniser, so a source
    // switch looks like a level change and may capture.
    assign cap_src = comparator_source_select ? comparator_output
                                              : capture_pin;

    tcu_edge u_cap_edge (
        .clk    (clk),
        .rst_b  (rst_b),
        .pin_in (cap_src),
        .rise   (cap_rise),
        .fall   (cap_fall)
    );

    tcu_edge u_t1_edge (
        .clk    (clk),
        .rst_b  (rst_b),
        .pin_in (t1_pin),
        .rise   (t1_rise),
        .fall   (t1_fall)
    );

    // ********************************************************
    // Mode decode.
    // ********************************************************
    assign mode = {s_q.ctl_b[CTLB_MODE_HI +: 2],
                   s_q.ctl_a[CTLA_MODE_LO +: 2]};
    assign csel = s_q.ctl_b[CTLB_CS +: 3];

    always_comb
    begin
        case (mode)
            M_PC8, M_FAST8:       top = TOP_8BIT;
            M_PC9, M_FAST9:       top = TOP_9BIT;
            M_PC10, M_FAST10:     top = TOP_10BIT;
            M_CTC_CMP, M_PFC_CMP,
            M_PC_CMP, M_FAST_CMP: top = s_q.cmpa;
            M_PFC_CAP, M_PC_CAP,
            M_CTC_CAP, M_FAST_CAP: top = s_q.capt;
            default:              top = CNT_MAX;
        endcase
    end

    assign dual    = (mode == M_PC8) || (mode == M_PC9) ||
                     (mode == M_PC10) || (mode == M_PFC_CAP) ||
                     (mode == M_PFC_CMP) || (mode == M_PC_CAP) ||
                     (mode == M_PC_CMP);
    assign cap_top = (mode == M_PFC_CAP) || (mode == M_PC_CAP) ||
                     (mode == M_CTC_CAP) || (mode == M_FAST_CAP);
    assign ovf_max = (mode == M_NORMAL) || (mode == M_CTC_CMP) ||
                     (mode == M_CTC_CAP);

    // ********************************************************
    // Tick selection.
    // ********************************************************
    always_comb
    begin
        case (csel)
            CS_STOP:     tick = 1'b0;
            CS_DIV1:     tick = 1'b1;
            CS_DIV8:     tick = (s_q.presc & PS_M8) == PS_M8;
            CS_DIV64:    tick = (s_q.presc & PS_M64) == PS_M64;
            CS_DIV256:   tick = (s_q.presc & PS_M256) == PS_M256;
            CS_DIV1024:  tick = s_q.presc == PS_M1024;
            CS_EXT_FALL: tick = t1_fall;
            CS_EXT_RISE: tick = t1_rise;
            default:     tick = 1'b0;
        endcase
    end

    // The capture input is idle while the capture register holds
    // the ceiling, so a stray edge cannot corrupt the period.
    assign cap_evt = !cap_top && (s_q.ctl_b[CTLB_EDGE] ? cap_rise
                                                       : cap_fall);

    // ********************************************************
    // Read mux.
    // ********************************************************
    always_comb
    begin
        case (io_addr)
            A_CNT_L:  rd_val = s_q.count[7:0];
            A_CNT_H:  rd_val = s_q.temp;
            A_CAP_L:  rd_val = s_q.capt[7:0];
            A_CAP_H:  rd_val = s_q.temp;
            A_CMPA_L: rd_val = s_q.cmpa[7:0];
            A_CMPA_H: rd_val = s_q.cmpa[15:8];
            A_CTL_A:  rd_val = s_q.ctl_a;
            A_CTL_B:  rd_val = s_q.ctl_b;
            A_FLAG:   rd_val = {2'h0, s_q.flag_cap, 4'h0, s_q.flag_ovf};
            A_MASK:   rd_val = {2'h0, s_q.msk_cap, 4'h0, s_q.msk_ovf};
            default:  rd_val = BYTE_RST;
        endcase
    end

    // ********************************************************
    // Next state.
    // ********************************************************
    always_comb
    begin
        s_d     = s_q;
        ovf_set = 1'b0;
        s_d.presc = (csel == CS_STOP) ? 10'h000 : s_q.presc + 10'h001;

        if (tick)
        begin
            if (dual)
            begin
                if (s_q.dir == TCU_UP)
                begin
                    if (s_q.count == top)
                    begin
                        s_d.dir   = TCU_DOWN;
                        s_d.count = s_q.count - CNT_ONE;
                    end
                    else
                    begin
                        s_d.count = s_q.count + CNT_ONE;
                    end
                end
                else
                begin
                    if (s_q.count == CNT_ZERO)
                    begin
                        s_d.dir   = TCU_UP;
                        s_d.count = s_q.count + CNT_ONE;
                    end
                    else
                    begin
                        s_d.count = s_q.count - CNT_ONE;
                        ovf_set   = s_q.count == CNT_ONE;
                    end
                end
            end
            else
            begin
                s_d.dir   = TCU_UP;
                s_d.count = (s_q.count == top) ? CNT_ZERO
                                               : s_q.count + CNT_ONE;
                ovf_set   = ovf_max ? (s_q.count == CNT_MAX)
                                    : (s_q.count == top);
            end
        end

        s_d.capt = cap_evt ? s_q.count : s_q.capt;

        if (io_rd)
        begin
            s_d.rdata = rd_val;
            if (io_addr == A_CNT_L)
            begin
                s_d.temp = s_q.count[15:8];
            end
            if (io_addr == A_CAP_L)
            begin
                s_d.temp = s_q.capt[15:8];
            end
        end

        if (io_wr)
        begin
            case (io_addr)
                A_CNT_L:  s_d.count = {s_q.temp, io_wdata};
                A_CNT_H,
                A_CAP_H,
                A_CMPA_H: s_d.temp = io_wdata;
                A_CAP_L:  s_d.capt = cap_top ? {s_q.temp, io_wdata}
                                             : s_d.capt;
                A_CMPA_L: s_d.cmpa = {s_q.temp, io_wdata};
                A_CTL_A:  s_d.ctl_a = io_wdata;
                A_CTL_B:  s_d.ctl_b = io_wdata;
                A_FLAG:
                begin
                    s_d.flag_ovf = s_q.flag_ovf & ~io_wdata[FLAG_OVF];
                    s_d.flag_cap = s_q.flag_cap & ~io_wdata[FLAG_CAP];
                end
                A_MASK:
                begin
                    s_d.msk_ovf = io_wdata[FLAG_OVF];
                    s_d.msk_cap = io_wdata[FLAG_CAP];
                end
                default:  s_d.temp = s_q.temp;
            endcase
        end

        // Set terms come last so that a new event beats any clear.
        s_d.flag_ovf = (s_d.flag_ovf & ~ovf_irq_ack) | ovf_set;
        s_d.flag_cap = (s_d.flag_cap & ~cap_irq_ack) | cap_evt;

        s_d.ovf_irq   = s_d.flag_ovf & s_d.msk_ovf;
        s_d.cap_irq   = s_d.flag_cap & s_d.msk_cap;
        s_d.top_hit   = s_d.count == top;
        s_d.floor_hit = s_d.count == CNT_ZERO;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q           <= '0;
            s_q.floor_hit <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign io_rdata        = s_q.rdata;
    assign ovf_irq         = s_q.ovf_irq;
    assign cap_irq         = s_q.cap_irq;
    assign count_top_hit   = s_q.top_hit;
    assign count_floor_hit = s_q.floor_hit;

    // ********************************************************
    // Checks.
    // ********************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_lo_read_latch;
        io_rd && !io_wr && io_addr == A_CNT_L
        |=> s_q.temp == $past(s_q.count[15:8]);
    endproperty
    a_lo_read_latch: assert property (p_lo_read_latch)
        else $error("count low read did not load the latch");

    property p_lo_write;
        io_wr && io_addr == A_CNT_L
        |=> s_q.count == {$past(s_q.temp), $past(io_wdata)};
    endproperty
    a_lo_write: assert property (p_lo_write)
        else $error("count low write did not load the count");

    property p_hi_write;
        io_wr && (io_addr == A_CNT_H || io_addr == A_CAP_H)
        |=> s_q.temp == $past(io_wdata);
    endproperty
    a_hi_write: assert property (p_hi_write)
        else $error("high byte write missed the latch");

    property p_latch_keep;
        io_wr && !io_rd && io_addr == A_CNT_L |=> $stable(s_q.temp);
    endproperty
    a_latch_keep: assert property (p_latch_keep)
        else $error("latch changed on low byte write");

    property p_stopped;
        (csel == CS_STOP && !io_wr) [*2] |-> $stable(s_q.count);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("count moved while stopped");

    property p_normal_inc;
        tick && mode == M_NORMAL && !(io_wr && io_addr == A_CNT_L)
        |=> s_q.count == $past(s_q.count) + CNT_ONE;
    endproperty
    a_normal_inc: assert property (p_normal_inc)
        else $error("normal mode tick did not increment");

    property p_capture;
        cap_evt |=> s_q.flag_cap && s_q.capt == $past(s_q.count);
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture copy or flag missing");

    property p_flag_clear;
        io_wr && io_addr == A_FLAG && io_wdata[FLAG_CAP] && !cap_evt
        |=> !s_q.flag_cap;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("capture flag not cleared by write");

    property p_cap_guard;
        io_wr && io_addr == A_CAP_L && !cap_top && !cap_evt
        |=> $stable(s_q.capt);
    endproperty
    a_cap_guard: assert property (p_cap_guard)
        else $error("capture register written in wrong mode");

    property p_floor;
        count_floor_hit == (s_q.count == CNT_ZERO);
    endproperty
    a_floor: assert property (p_floor)
        else $error("floor signal disagrees with count");

    property p_cap_irq;
        cap_irq == (s_q.flag_cap && s_q.msk_cap);
    endproperty
    a_cap_irq: assert property (p_cap_irq)
        else $error("capture request disagrees with flag");

    c_capture: cover property (cap_evt && s_q.msk_cap);
    c_overflow: cover property (ovf_set ##1 ovf_irq);
    c_reverse: cover property (dual && tick && s_q.dir == TCU_DOWN);

endmodule : tcu_core
`default_nettype wire

// File: bench/tcu_cpu.sv
`timescale 1ns/1ps
`default_nettype none
module tcu_cpu
    import tcu_pkg::*;
(
    input  wire logic       clk,
    output logic      [3:0] io_addr,
    output logic            io_wr,
    output logic            io_rd,
    output logic      [7:0] io_wdata,
    input  wire logic [7:0] io_rdata
);
    // ********************************************************
    // Processor bus cycles.
    // ********************************************************
    // Callers may split a two-byte access; t_latch reuses the latch for a lone A_CMPA_L write.
    initial
    begin
        io_addr  = 4'h0;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge clk);
        io_wr    <= 1'b0;
        io_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge clk);
        io_rd   <= 1'b0;
        #1;
        d = io_rdata;
    endtask : rd
    task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
        wr(lo + 4'h1, v[15:8]);
        wr(lo, v[7:0]);
    endtask : wr16
    task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
        rd(lo, v[7:0]);
        rd(lo + 4'h1, v[15:8]);
    endtask : rd16
endmodule : tcu_cpu
`default_nettype wire

// File: bench/tcu_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module tcu_core_test
    import tcu_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  io_addr;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic        cap_pin = 1'b0;
    logic        t1 = 1'b0;
    logic        cmp_out = 1'b0;
    logic        cmp_sel = 1'b0;
    logic        ovf_ack = 1'b0;
    logic        cap_ack = 1'b0;
    logic        ovf_irq;
    logic        cap_irq;
    logic        top_hit;
    logic        floor_hit;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    logic [15:0] v;
    logic [7:0]  b;
    always #2.5 clk = ~clk;
    tcu_cpu tcu_cpu_inst (.clk(clk), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));
    tcu_core tcu_core_inst (.clk(clk), .rst_b(rst_b), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .t1_pin(t1), .capture_pin(cap_pin),
        .comparator_output(cmp_out), .comparator_source_select(cmp_sel),
        .ovf_irq_ack(ovf_ack), .cap_irq_ack(cap_ack), .ovf_irq(ovf_irq),
        .cap_irq(cap_irq), .count_top_hit(top_hit),
        .count_floor_hit(floor_hit));
    // ********************************************************
    // Checking and closing.
    // ********************************************************
    task automatic complete_run;
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit
    // A hang costs far more cycles than the whole sequence needs.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    // ********************************************************
    // Scenarios.
    // ********************************************************
    task automatic t_reset;
        tcu_cpu_inst.rd16(A_CNT_L, v);
        chk(v, 16'h0000);
        tcu_cpu_inst.rd16(A_CAP_L, v);
        chk(v, 16'h0000);
        tcu_cpu_inst.rd(A_FLAG, b);
        chk(16'(b), 16'h0000);
        chk_bit(floor_hit, 1'b1);
        chk_bit(top_hit, 1'b0);
    endtask : t_reset
    task automatic t_latch;
        tcu_cpu_inst.wr16(A_CNT_L, 16'h1234);
        repeat (20) @(posedge clk);
        tcu_cpu_inst.rd16(A_CNT_L, v);
        chk(v, 16'h1234);
        tcu_cpu_inst.wr(A_CNT_H, 8'hab);
        tcu_cpu_inst.wr(A_CNT_L, 8'h01);
        tcu_cpu_inst.wr(A_CMPA_L, 8'h02);
        tcu_cpu_inst.rd16(A_CNT_L, v);
        chk(v, 16'hab01);
        tcu_cpu_inst.rd16(A_CMPA_L, v);
        chk(v, 16'hab02);
    endtask : t_latch
    // The carry into the high byte lands on the same edge that samples the second read.
    task automatic t_atomic;
        tcu_cpu_inst.wr16(A_CNT_L, 16'h10fc);
        tcu_cpu_inst.wr(A_CTL_B, {5'h00, CS_DIV1});
        tcu_cpu_inst.rd16(A_CNT_L, v);
        tcu_cpu_inst.wr(A_CTL_B, 8'h00);
        chk_bit(v[7:0] > 8'hfc, 1'b1);
        chk(16'(v[15:8]), 16'h0010);
    endtask : t_atomic
    task automatic t_ovf;
        tcu_cpu_inst.wr(A_MASK, 8'h01);
        tcu_cpu_inst.wr16(A_CNT_L, 16'hfffd);
        tcu_cpu_inst.wr(A_CTL_B, {5'h00, CS_DIV1});
        repeat (10) @(posedge clk);
        tcu_cpu_inst.wr(A_CTL_B, 8'h00);
        chk_bit(ovf_irq, 1'b1);
        tcu_cpu_inst.rd(A_FLAG, b);
        chk(16'(b), 16'h0001);
        @(posedge clk);
        ovf_ack <= 1'b1;
        @(posedge clk);
        ovf_ack <= 1'b0;
        repeat (2) @(posedge clk);
        chk_bit(ovf_irq, 1'b0);
    endtask : t_ovf
    task automatic t_cap;
        tcu_cpu_inst.wr(A_MASK, 8'h20);
        tcu_cpu_inst.wr16(A_CNT_L, 16'h4321);
        tcu_cpu_inst.wr(A_CTL_B, 8'h40);
        cap_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk_bit(cap_irq, 1'b1);
        tcu_cpu_inst.rd16(A_CAP_L, v);
        chk(v, 16'h4321);
        tcu_cpu_inst.wr(A_FLAG, 8'h20);
        cap_pin <= 1'b0;
        repeat (8) @(posedge clk);
        tcu_cpu_inst.rd(A_FLAG, b);
        chk(16'(b), 16'h0000);
        tcu_cpu_inst.wr(A_CTL_B, 8'h00);
        tcu_cpu_inst.wr16(A_CNT_L, 16'h0777);
        cap_pin <= 1'b1;
        repeat (8) @(posedge clk);
        tcu_cpu_inst.rd(A_FLAG, b);
        chk(16'(b), 16'h0000);
        @(posedge clk);
        cap_pin <= 1'b0;
        repeat (8) @(posedge clk);
        tcu_cpu_inst.rd16(A_CAP_L, v);
        chk(v, 16'h0777);
        @(posedge clk);
        cap_ack <= 1'b1;
        @(posedge clk);
        cap_ack <= 1'b0;
        repeat (2) @(posedge clk);
        chk_bit(cap_irq, 1'b0);
        tcu_cpu_inst.wr(A_CTL_B, 8'h40);
        tcu_cpu_inst.wr16(A_CNT_L, 16'h0999);
        cmp_sel <= 1'b1;
        repeat (8) @(posedge clk);
        cmp_out <= 1'b1;
        repeat (8) @(posedge clk);
        tcu_cpu_inst.rd16(A_CAP_L, v);
        chk(v, 16'h0999);
    endtask : t_cap
    task automatic t_ceiling;
        tcu_cpu_inst.wr16(A_CAP_L, 16'h0234);
        tcu_cpu_inst.rd16(A_CAP_L, v);
        chk(v, 16'h0999);
        tcu_cpu_inst.wr(A_CTL_B, 8'h18);
        tcu_cpu_inst.wr16(A_CAP_L, 16'h0234);
        tcu_cpu_inst.rd16(A_CAP_L, v);
        chk(v, 16'h0234);
        tcu_cpu_inst.wr16(A_CNT_L, 16'h0234);
        repeat (2) @(posedge clk);
        chk_bit(top_hit, 1'b1);
        tcu_cpu_inst.wr(A_CTL_A, 8'h01);
        tcu_cpu_inst.wr(A_CTL_B, 8'h08);
        tcu_cpu_inst.wr16(A_CNT_L, 16'h00ff);
        repeat (2) @(posedge clk);
        chk_bit(top_hit, 1'b1);
        tcu_cpu_inst.wr16(A_CNT_L, 16'h0000);
        repeat (2) @(posedge clk);
        chk_bit(floor_hit, 1'b1);
    endtask : t_ceiling
    // Dual slope on the external tick: up to the ceiling, then down.
    task automatic t_tick;
        tcu_cpu_inst.wr(A_CTL_A, 8'h01);
        tcu_cpu_inst.wr(A_CTL_B, {5'h00, CS_EXT_RISE});
        tcu_cpu_inst.wr16(A_CNT_L, 16'h00fe);
        repeat (3)
        begin
            t1 <= 1'b1;
            repeat (4) @(posedge clk);
            t1 <= 1'b0;
            repeat (4) @(posedge clk);
        end
        tcu_cpu_inst.rd16(A_CNT_L, v);
        chk(v, 16'h00fd);
    endtask : t_tick
    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_latch();
        t_atomic();
        t_ovf();
        t_cap();
        t_ceiling();
        t_tick();
        complete_run();
    end
endmodule : tcu_core_test
`default_nettype wire
